// ==== rtl/sigmon_regs.vh ====
// Register offsets, field positions, reset values and sizes of the signal monitor bank.
`ifndef SIGMON_REGS_VH
`define SIGMON_REGS_VH
`define ADDR_OUTCOME 8'h37
`define ADDR_ERROR 8'h38
`define ADDR_STRENGTH 8'h39
`define ADDR_MATCH_CTRL 8'h3A
`define ADDR_PAT0 8'h3B
`define ADDR_PAT1 8'h3C
`define ADDR_PAT2 8'h3D
`define ADDR_PAT3 8'h3E
`define FAIL_BIT 7
`define TOL_MSB 6
`define TOL_LSB 5
`define LEN_MSB 4
`define LEN_LSB 0
`define CTRL_RESET 8'h00
`define PAT_BYTE_RESET 8'h00
`define CTRL_WMASK 8'h7F
`define FULL_LEN 6'h20
`define SRC_AUTO 1'b0
`define SRC_READ 1'b1
`endif

// ==== rtl/chip_mismatch_counter.v ====
// Counts chip mismatches inside the configured pattern window.
`timescale 1ns/1ps
`default_nettype none
module chip_mismatch_counter (
   // Compared words.
   input wire [31:0] chips,
   input wire [31:0] pattern,
   // Window length, 1 to 32.
   input wire [5:0] length,
   // Mismatch count.
   output reg [5:0] errors
);
   integer i;

   // Adds one for every differing chip below the window length.
   always @* begin
      errors = 6'h00;
      for (i = 0; i < 32; i = i + 1) begin
         if ((i < length) && (chips[i] != pattern[i])) begin
            errors = errors + 6'h01;
         end
      end
   end
endmodule // chip_mismatch_counter
`default_nettype wire

// ==== rtl/preamble_sigmon_status_regs.v ====
// Signal monitor status, error, strength and preamble match register bank.
// Operation
// (R1) Outcome bit 7: one on failure.
// (R2) Outcome bits 6..0 report seven check causes.
// (R3) Error register: bit 7 pattern timeout, causes.
// (R4) Top bits pair: none, impossible, ok, error; code reads 0/0 for none or pass, 1/0 failure, 1/1 timeout failure.
// (R5) Strength loads on completion or host sample.
// (R6) Tolerance field bits 6..5 allows 0..3 mismatches.
// (R7) Length field 1..31 direct, zero means 32.
// (R8) Pattern byte 0 holds chips 7..0.
// (R9) Bytes 1..3 hold chips 15..8, 23..16, 31..24.
// (R10) Sample on completion or status read; record source.
// (R11) Match when mismatches within tolerance over length.
`timescale 1ns/1ps
`default_nettype none
`include "sigmon_regs.vh"
module preamble_sigmon_status_regs (
   // Clock and reset.
   input wire clk_sys,
   input wire resetn,
   // Register access from the serial control interface.
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Completion of a search or detection, with its outcome.
   input wire search_done,
   input wire search_failed,
   input wire pattern_timeout,
   input wire [6:0] check_causes,
   input wire [7:0] signal_strength_value,
   // Host request to sample the receive status.
   input wire sample_request,
   // Live chip stream, most significant chip first.
   input wire chip_valid,
   input wire chip_data,
   // Match result, sample source and the decoded tolerance and length.
   output wire preamble_match,
   output reg sample_source_flag,
   output wire [1:0] chip_error_tolerance,
   output wire [5:0] pattern_length_chips
);
   // Stored status: outcome flags, error flags and the sampled strength.
   reg [7:0] outcome_r;
   reg [7:0] outcome_nxt;
   reg [7:0] error_r;
   reg [7:0] error_nxt;
   reg [7:0] strength_r;
   reg [7:0] strength_nxt;

   // Decision and failure memory of the most recent completion.
   reg decided_r;
   reg decided_nxt;
   reg failed_r;
   reg failed_nxt;
   reg source_nxt;

   // Host settings: control byte and the four pattern bytes.
   reg [7:0] ctrl_r;
   reg [7:0] ctrl_nxt;
   reg [7:0] pat_mem_r [0:3];

   // Recent chips, newest in bit 0.
   reg [31:0] chips_r;
   reg [31:0] chips_nxt;

   // Read data about to be registered.
   reg [7:0] rdata_nxt;

   // Decoded views of the stored settings.
   wire [31:0] pattern_word;
   wire [5:0] mismatches;
   wire [5:0] tolerance_wide;
   wire [4:0] length_field;
   wire status_read;
   wire resample;
   wire [1:0] pat_sel;
   wire pat_hit;
   wire outcome_top;
   wire error_top;

   // Address decode, one select per register.
   wire sel_outcome;
   wire sel_error;
   wire sel_strength;
   wire sel_ctrl;
   wire sel_pat0;
   wire sel_pat1;
   wire sel_pat2;
   wire sel_pat3;

   // Write strobes of the read-write registers.
   wire wr_ctrl;
   wire wr_pat;

   // Cause bits by name, in register order.
   wire cause_chip_timeout;
   wire cause_chip_timing;
   wire cause_coding;
   wire cause_baud_rate;
   wire cause_strength_level;
   wire cause_amp_high;
   wire cause_amp_low;
   wire [6:0] causes_packed;
   wire [6:0] error_causes;
   wire error_timeout;

   // Loop index for the pattern memory reset.
   integer k;

   // One select per register address.
   assign sel_outcome = (reg_addr == `ADDR_OUTCOME);
   assign sel_error = (reg_addr == `ADDR_ERROR);
   assign sel_strength = (reg_addr == `ADDR_STRENGTH);
   assign sel_ctrl = (reg_addr == `ADDR_MATCH_CTRL);
   assign sel_pat0 = (reg_addr == `ADDR_PAT0);
   assign sel_pat1 = (reg_addr == `ADDR_PAT1);
   assign sel_pat2 = (reg_addr == `ADDR_PAT2);
   assign sel_pat3 = (reg_addr == `ADDR_PAT3);

   // Any of the four pattern bytes; the low address bits then pick the byte.
   assign pat_hit = sel_pat0 | sel_pat1 | sel_pat2 | sel_pat3;
   assign pat_sel = reg_addr[1:0] - 2'h3; // R8 R9

   // Writes reach only the read-write registers; status registers ignore them.
   assign wr_ctrl = reg_wr & sel_ctrl; // R6 R7
   assign wr_pat = reg_wr & pat_hit; // R8 R9

   // A read of a status register resamples the live strength and marks the source.
   assign status_read = reg_rd & (sel_outcome | sel_error | sel_strength); // R10
   assign resample = sample_request | status_read; // R5 R10

   // Tolerance and length decode; zero length selects the full pattern.
   assign length_field = ctrl_r[`LEN_MSB:`LEN_LSB];
   assign chip_error_tolerance = ctrl_r[`TOL_MSB:`TOL_LSB]; // R6
   assign pattern_length_chips = (length_field == 5'h00) ? `FULL_LEN : {1'b0, length_field}; // R7
   assign tolerance_wide = {4'h0, chip_error_tolerance}; // R6

   // The four bytes form the reference word, byte 0 in the low chips.
   assign pattern_word = {pat_mem_r[3], pat_mem_r[2], pat_mem_r[1], pat_mem_r[0]}; // R8 R9

   // Cause inputs by name, highest bit first.
   assign cause_chip_timeout = check_causes[6]; // R2
   assign cause_chip_timing = check_causes[5]; // R2
   assign cause_coding = check_causes[4]; // R2
   assign cause_baud_rate = check_causes[3]; // R2
   assign cause_strength_level = check_causes[2]; // R2
   assign cause_amp_high = check_causes[1]; // R2
   assign cause_amp_low = check_causes[0]; // R2
   assign causes_packed = {cause_chip_timeout, cause_chip_timing, cause_coding, cause_baud_rate,
      cause_strength_level, cause_amp_high, cause_amp_low}; // R2

   // Error causes are kept only for a failed completion, so a pass leaves them clear.
   assign error_causes = search_failed ? causes_packed : 7'h00; // R3
   assign error_timeout = search_failed & pattern_timeout; // R3

   // Mismatch counter over the configured window.
   chip_mismatch_counter u_count (
      .chips(chips_r),
      .pattern(pattern_word),
      .length(pattern_length_chips),
      .errors(mismatches)
   );

   // Match when the differing chips stay within the tolerance.
   assign preamble_match = (tolerance_wide >= mismatches); // R11

   // Next chip window: a valid chip shifts in at the low end.
   always @* begin
      chips_nxt = chips_r;
      if (chip_valid) begin
         chips_nxt = {chips_r[30:0], chip_data}; // R11
      end
   end

   // Chip window register.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chips_r <= 32'h00000000;
      end else begin
         chips_r <= chips_nxt;
      end
   end

   // Next control value; the reserved bit is masked so it always reads zero.
   always @* begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = reg_wdata & `CTRL_WMASK; // R6 R7
      end
   end

   // Control register.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= `CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Pattern bytes, addressed by the byte index.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (k = 0; k < 4; k = k + 1) begin
            pat_mem_r[k] <= `PAT_BYTE_RESET;
         end
      end else if (wr_pat) begin
         pat_mem_r[pat_sel] <= reg_wdata; // R8 R9
      end
   end

   // Next status: a completion loads everything, a host sample only the strength and the source flag.
   // A completion outranks a sample in the same cycle, so the source reads automatic.
   always @* begin
      outcome_nxt = outcome_r;
      error_nxt = error_r;
      strength_nxt = strength_r;
      decided_nxt = decided_r;
      failed_nxt = failed_r;
      source_nxt = sample_source_flag;
      if (search_done) begin
         outcome_nxt = {1'b1, causes_packed}; // R1 R2
         error_nxt = {error_timeout, error_causes}; // R3
         decided_nxt = 1'b1; // R4
         failed_nxt = search_failed; // R1
         strength_nxt = signal_strength_value; // R5
         source_nxt = `SRC_AUTO; // R10
      end else if (resample) begin
         strength_nxt = signal_strength_value; // R5
         source_nxt = `SRC_READ; // R10
      end
   end

   // Status registers.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         outcome_r <= 8'h00;
         error_r <= 8'h00;
         strength_r <= 8'h00;
         decided_r <= 1'b0;
         failed_r <= 1'b0;
         sample_source_flag <= `SRC_AUTO;
      end else begin
         outcome_r <= outcome_nxt;
         error_r <= error_nxt;
         strength_r <= strength_nxt;
         decided_r <= decided_nxt;
         failed_r <= failed_nxt;
         sample_source_flag <= source_nxt;
      end
   end

   // Top bits: both stay zero until a decision exists, so 0/1 never shows.
   assign outcome_top = decided_r & failed_r; // R1 R4
   assign error_top = decided_r & failed_r & error_r[`FAIL_BIT]; // R3 R4

   // Read data mux; unmapped addresses and the reserved bit read zero.
   always @* begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `ADDR_OUTCOME: rdata_nxt = {outcome_top, outcome_r[6:0]}; // R1 R2
         `ADDR_ERROR: rdata_nxt = {error_top, error_r[6:0]}; // R3 R4
         `ADDR_STRENGTH: rdata_nxt = strength_r; // R5
         `ADDR_MATCH_CTRL: rdata_nxt = ctrl_r; // R6 R7
         `ADDR_PAT0: rdata_nxt = pat_mem_r[pat_sel]; // R8
         `ADDR_PAT1: rdata_nxt = pat_mem_r[pat_sel]; // R9
         `ADDR_PAT2: rdata_nxt = pat_mem_r[pat_sel]; // R9
         `ADDR_PAT3: rdata_nxt = pat_mem_r[pat_sel]; // R9
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Read data register; it holds its value until the next read.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end
endmodule // preamble_sigmon_status_regs
`default_nettype wire

// ==== dv/sigmon_monitor.sv ====
// Assertions on the signal monitor register bank ports.
`timescale 1ns/1ps
`default_nettype none
module sigmon_monitor (
   // Bus, events and decoded outputs.
   input wire clk_sys, input wire resetn, input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata, input wire reg_wr, input wire reg_rd, input wire [7:0] reg_rdata,
   input wire search_done, input wire search_failed, input wire sample_request,
   input wire sample_source_flag, input wire [1:0] chip_error_tolerance,
   input wire [5:0] pattern_length_chips
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Failed completion, then a quiet cycle; pattern write, then a quiet cycle.
   sequence s_fail; search_done && search_failed ##1 !search_done; endsequence
   sequence s_pat_wr; reg_wr && reg_addr == 8'h3B ##1 !reg_wr; endsequence
   wire ctl_wr = reg_wr && reg_addr == 8'h3A;
   a_fail_flag: assert property (s_fail ##1 reg_rd && reg_addr == 8'h37 && !search_done |=> reg_rdata[7])
      else $error("fail flag low");
   a_tol_field: assert property (ctl_wr |=> chip_error_tolerance == $past(reg_wdata[6:5]))
      else $error("tolerance");
   a_len_field: assert property (ctl_wr |=> pattern_length_chips ==
      ($past(reg_wdata[4:0]) == 5'h00 ? 6'h20 : {1'h0, $past(reg_wdata[4:0])})) else $error("length");
   a_src_auto: assert property (search_done && !reg_rd && !sample_request |=> !sample_source_flag)
      else $error("source auto");
   a_src_read: assert property (reg_rd && reg_addr == 8'h37 && !search_done |=> sample_source_flag)
      else $error("source read");
   a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h37 || reg_addr > 8'h3E) |=> reg_rdata == 8'h00)
      else $error("unmapped");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
   a_pat_readback: assert property (s_pat_wr ##1 reg_rd && reg_addr == 8'h3B |=>
      reg_rdata == $past(reg_wdata, 3)) else $error("pattern");
endmodule // sigmon_monitor
bind preamble_sigmon_status_regs sigmon_monitor u_mon (.*);
`default_nettype wire

// ==== dv/chip_source.sv ====
// Chip stream source standing in for the receiver front end.
`timescale 1ns/1ps
`default_nettype none
module chip_source (
   // Clock and chip stream.
   input wire clk_sys, output logic chip_valid, output wire chip_data
);
   logic bit_r = 1'h0;
   initial chip_valid = 1'h0;
   // Outside a frame the line shows the inverse of the last chip.
   assign chip_data = chip_valid ? bit_r : ~bit_r;
   // Sends the low n chips of w, most significant chip first.
   task send(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_sys); chip_valid <= 1'h1; bit_r <= w[i];
      end
      @(posedge clk_sys); chip_valid <= 1'h0;
   endtask
endmodule // chip_source
`default_nettype wire

// ==== dv/test_preamble_sigmon_status_regs.sv ====
// Self-checking bench for the signal monitor register bank.
`timescale 1ns/1ps
`default_nettype none
module test_preamble_sigmon_status_regs;
   logic clk_sys = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, search_done = 1'h0;
   logic search_failed = 1'h0, pattern_timeout = 1'h0, sample_request = 1'h0, pend = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, signal_strength_value = 8'h00;
   logic [7:0] reg_rdata, p0, c, exp_q[$];
   logic [6:0] check_causes = 7'h00;
   logic [1:0] chip_error_tolerance;
   logic [5:0] pattern_length_chips;
   logic chip_valid, chip_data, preamble_match, sample_source_flag;
   int fails = 0, checks_done = 0;
   integer seed = 69501;
   always #5 clk_sys = ~clk_sys;
   preamble_sigmon_status_regs u_dut (.*);
   chip_source u_src (.*);
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++; $display("ERROR %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // One bus cycle; a read notes its expected data.
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_wr <= w; reg_rd <= !w;
      if (!w) exp_q.push_back(d);
      @(posedge clk_sys); reg_wr <= 1'h0; reg_rd <= 1'h0;
   endtask
   task ev(input logic f, input logic [6:0] k);
      @(posedge clk_sys); search_done <= 1'h1; search_failed <= f; pattern_timeout <= f;
      check_causes <= k;
      @(posedge clk_sys); search_done <= 1'h0;
   endtask
   // Read data is compared one edge after the read was taken.
   always @(posedge clk_sys) begin
      if (pend) chk(reg_rdata, exp_q.pop_front());
      pend <= reg_rd;
   end
   task close_out;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin #100000; fails++; close_out; end
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'h1;
      chk(8'(pattern_length_chips), 8'h20);
      acc(0, 8'h37, 8'h00); acc(0, 8'h38, 8'h00); acc(0, 8'h40, 8'h00);
      for (int i = 0; i < 4; i++) begin
         c = 8'($random(seed)); acc(1, 8'(8'h3B + i), c);
         acc(0, 8'(8'h3B + i), c);
         if (i == 0) p0 = c;
      end
      for (int t = 0; t < 4; t++) begin
         acc(1, 8'h3A, {1'h1, 2'(t), 5'(t * 9)}); acc(0, 8'h3A, {1'h0, 2'(t), 5'(t * 9)});
         chk(8'(chip_error_tolerance), 8'(t));
         chk(8'(pattern_length_chips), t ? 8'(t * 9) : 8'h20);
      end
      c = 8'($random(seed)); signal_strength_value <= 8'h5A; ev(1, c[6:0]);
      acc(0, 8'h37, {1'h1, c[6:0]}); acc(0, 8'h38, {1'h1, c[6:0]});
      acc(0, 8'h39, 8'h5A);
      signal_strength_value <= 8'hC3; sample_request <= 1'h1;
      @(posedge clk_sys); sample_request <= 1'h0;
      acc(0, 8'h39, 8'hC3); chk(sample_source_flag, 8'h01);
      acc(1, 8'h39, 8'hFF); acc(0, 8'h39, 8'hC3);
      ev(0, 7'h00); acc(0, 8'h37, 8'h00);
      acc(0, 8'h38, 8'h00);
      acc(1, 8'h3A, 8'h28); u_src.send({24'h0, p0 ^ 8'h01}, 8);
      @(posedge clk_sys); chk(preamble_match, 8'h01);
      u_src.send({24'h0, p0 ^ 8'h03}, 8);
      @(posedge clk_sys); chk(preamble_match, 8'h00);
      repeat (2) @(posedge clk_sys);
      close_out;
   end
endmodule // test_preamble_sigmon_status_regs
`default_nettype wire
